//--- rtl/acc_converter_control.sv
// Control logic of a 10-bit successive-approximation converter with APB registers
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "acc_map.svh"
module acc_converter_control
    import acc_pkg::*;
#(
    parameter int STAB_CYCLES = `ACC_STAB_CYCLES
)
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic compareHigh,
    input wire logic overUpper,
    input wire logic underLower,
    input wire logic haltMode,
    output acc_analog_req_type analogReq,
    output logic converterPowered,
    output logic stabilizing
);
    logic rstMeta;
    logic rstSync;
    logic cmpMeta;
    logic cmpSync;
    logic overMeta;
    logic overSync;
    logic underMeta;
    logic underSync;
    logic haltMeta;
    logic haltSync;
    acc_csr_type csr;
    logic [9:0] result;
    acc_state_type state;
    acc_state_type next_state;
    logic [1:0] divCount;
    logic [3:0] stepCount;
    logic [9:0] trial;
    logic [9:0] workBits;
    logic settled;
    logic [31:0] stabCount;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end
        else
        begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end

    // Analog comparator outputs are asynchronous to this clock
    always_ff @(posedge clk_sys or negedge rstSync)
    begin
        if (!rstSync)
        begin
            cmpMeta <= 1'b0;
            cmpSync <= 1'b0;
            overMeta <= 1'b0;
            overSync <= 1'b0;
            underMeta <= 1'b0;
            underSync <= 1'b0;
            haltMeta <= 1'b0;
            haltSync <= 1'b0;
        end
        else
        begin
            cmpMeta <= compareHigh;
            cmpSync <= cmpMeta;
            overMeta <= overUpper;
            overSync <= overMeta;
            underMeta <= underLower;
            underSync <= underMeta;
            haltMeta <= haltMode;
            haltSync <= haltMeta;
        end
    end

    function automatic logic hitOffset(input logic [11:0] addr, input logic [11:0] offset);
        hitOffset = (addr == offset);
    endfunction

    wire logic access = psel && penable;
    wire logic hitCsr = hitOffset(paddr, `ACC_OFF_CSR);
    wire logic hitHigh = hitOffset(paddr, `ACC_OFF_HIGH);
    wire logic hitLow = hitOffset(paddr, `ACC_OFF_LOW);
    wire logic mapped = hitCsr || hitHigh || hitLow;
    wire logic csrWrite = access && pwrite && hitCsr;
    wire logic highRead = access && !pwrite && hitHigh;
    wire logic [3:0] newChannel = pwdata[3:0];
    // Halt overrides the enable bit; wait mode has no input here at all (R18)
    wire logic running = csr.on && !haltSync; // R19
    wire logic channelChange = csrWrite && (newChannel != csr.channel); // R12
    wire logic abortNow = !running || channelChange; // R6
    // Converter clock tick: every 4th or every 2nd system cycle
    wire logic tick = csr.speed ? divCount[0] : (divCount == 2'b11); // R13
    wire logic lastStep = (stepCount == 4'd0);
    wire logic done = (state == ACC_CONVERT) && tick && settled && lastStep && !abortNow;
    wire logic [9:0] decided = cmpSync ? (trial & ~workBits) : trial;
    wire logic [9:0] finalResult = overSync ? `ACC_FULL_SCALE : // R1
        (underSync ? `ACC_RESULT_RESET : decided); // R2
    wire logic [7:0] csrRead = {csr.eoc, csr.speed, csr.on, 1'b0, csr.channel};
    wire logic [31:0] readMux = hitCsr ? {24'h0000_00, csrRead} :
        hitHigh ? {24'h0000_00, result[9:2]} : // R16
        hitLow ? {30'h0000_0000, result[1:0]} : 32'h0000_0000; // R17

    // Control register; flag set wins over any clear in the same cycle
    always_ff @(posedge clk_sys or negedge rstSync)
    begin
        if (!rstSync)
        begin
            csr <= `ACC_CSR_RESET; // R15
        end
        else
        begin
            if (csrWrite)
            begin
                csr.speed <= pwdata[`ACC_BIT_SPEED]; // R13
                csr.on <= pwdata[`ACC_BIT_ON]; // R5
                csr.rsvd <= 1'b0; // R14
                csr.channel <= newChannel; // R4
            end
            if (done)
            begin
                csr.eoc <= 1'b1; // R7
            end
            else if (csrWrite || highRead)
            begin
                csr.eoc <= 1'b0; // R8
            end
        end
    end

    // Result is not held for the reader; every completion overwrites it
    always_ff @(posedge clk_sys or negedge rstSync)
    begin
        if (!rstSync)
        begin
            result <= `ACC_RESULT_RESET;
        end
        else if (done)
        begin
            result <= finalResult; // R9
        end
    end

    always_ff @(posedge clk_sys or negedge rstSync)
    begin
        if (!rstSync)
        begin
            divCount <= 2'b00;
        end
        else
        begin
            divCount <= abortNow ? 2'b00 : divCount + 2'b01;
        end
    end

    always_comb
    begin
        next_state = state;
        case (state)
            ACC_IDLE:
            begin
                if (running)
                begin
                    next_state = ACC_SAMPLE; // R5
                end
            end
            ACC_SAMPLE:
            begin
                if (tick && lastStep)
                begin
                    next_state = ACC_CONVERT;
                end
            end
            ACC_CONVERT:
            begin
                if (done)
                begin
                    next_state = ACC_SAMPLE; // R21
                end
            end
            default:
            begin
                next_state = ACC_IDLE;
            end
        endcase
        if (abortNow)
        begin
            next_state = running ? ACC_SAMPLE : ACC_IDLE; // R12
        end
    end

    // Successive approximation: one bit per two converter ticks, since the
    // trial-to-comparator loop needs three system cycles to settle
    always_ff @(posedge clk_sys or negedge rstSync)
    begin
        if (!rstSync)
        begin
            state <= ACC_IDLE;
            stepCount <= 4'h0;
            trial <= 10'h000;
            workBits <= 10'h000;
            settled <= 1'b0;
        end
        else
        begin
            state <= next_state;
            if (abortNow || (state == ACC_IDLE) || done)
            begin
                stepCount <= `ACC_SAMPLE_TICKS;
                trial <= 10'h200;
                workBits <= 10'h200;
                settled <= 1'b0;
            end
            else if (tick)
            begin
                if (state == ACC_SAMPLE)
                begin
                    stepCount <= lastStep ? 4'd9 : stepCount - 4'd1;
                end
                else
                begin
                    settled <= !settled;
                    if (settled)
                    begin
                        stepCount <= stepCount - 4'd1;
                        trial <= decided | (workBits >> 1); // R21
                        workBits <= workBits >> 1;
                    end
                end
            end
        end
    end

    // Stabilization interval after leaving halt
    always_ff @(posedge clk_sys or negedge rstSync)
    begin
        if (!rstSync)
        begin
            stabCount <= 32'h0000_0000;
            stabilizing <= 1'b0;
        end
        else if (haltSync)
        begin
            stabCount <= STAB_CYCLES; // R19
            stabilizing <= 1'b1;
        end
        else
        begin
            stabCount <= (stabCount != 32'h0000_0000) ? stabCount - 32'h0000_0001 : stabCount;
            stabilizing <= (stabCount > 32'h0000_0001);
        end
    end

    // Zero-wait APB slave; unmapped addresses answer with an error
    always_ff @(posedge clk_sys or negedge rstSync)
    begin
        if (!rstSync)
        begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            analogReq <= '0;
            converterPowered <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata <= (psel && !penable && !pwrite) ? readMux : 32'h0000_0000;
            analogReq.sample <= (next_state == ACC_SAMPLE);
            analogReq.channel <= channelChange ? newChannel : csr.channel; // R4
            analogReq.trial <= trial;
            converterPowered <= running; // R19
        end
    end
endmodule
`default_nettype wire

//--- pkg/acc_map.svh
// Register map, field positions, reset values and timing counts of the converter control
// What the document requires
// (R1) Above upper reference: result FFh, 03h
// (R2) Below lower reference: result all zero
// (R3) Port logic sets analog pins plain input
// (R4) Four-bit field selects input 0 to 15
// (R5) Converter-on starts continuous conversions
// (R6) Clearing converter-on stops conversion
// (R7) Completion sets flag and loads results
// (R8) Read high or write control clears flag
// (R9) Each conversion overwrites both result bytes
// (R10) Software reads low then high quickly
// (R11) Eight-bit read: high byte only
// (R12) Channel change aborts, clears flag, restarts
// (R13) Bit 6 picks divide by four or two
// (R14) Software writes zero to bit 4
// (R15) Control register resets to zero
// (R16) High byte holds result bits 9:2
// (R17) Low byte holds bits 1:0, rest zero
// (R18) Wait mode leaves converter untouched
// (R19) Halt disables converter; stabilize after wake
// (R20) No interrupt; completion found by polling
// (R21) Sequence conversions back to back
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH
`define ACC_OFF_CSR 12'h000
`define ACC_OFF_HIGH 12'h004
`define ACC_OFF_LOW 12'h008
`define ACC_BIT_EOC 7
`define ACC_BIT_SPEED 6
`define ACC_BIT_ON 5
`define ACC_BIT_RSVD 4
`define ACC_CSR_RESET 8'h00
`define ACC_RESULT_RESET 10'h000
`define ACC_FULL_SCALE 10'h3FF
`define ACC_CONV_BITS 10
`define ACC_SAMPLE_TICKS 4'h3
`define ACC_STAB_NS 10000
`define ACC_STAB_CYCLES ((`ACC_STAB_NS + 4) / 5)
`endif

//--- pkg/acc_pkg.sv
// Types shared by the converter control
package acc_pkg;
    typedef enum logic [1:0]
    {
        ACC_IDLE = 2'b00,
        ACC_SAMPLE = 2'b01,
        ACC_CONVERT = 2'b10
    } acc_state_type;

    typedef struct packed
    {
        logic eoc;
        logic speed;
        logic on;
        logic rsvd;
        logic [3:0] channel;
    } acc_csr_type;

    typedef struct packed
    {
        logic sample;
        logic [3:0] channel;
        logic [9:0] trial;
    } acc_analog_req_type;
endpackage

//--- dv/acc_analog_model.sv
// Analog side: per-channel input levels and comparator
`timescale 1ns/1ps
`default_nettype none
module acc_analog_model
    import acc_pkg::*;
(
    input wire acc_analog_req_type analogReq,
    output logic compareHigh,
    output logic overUpper,
    output logic underLower
);
    logic [9:0] level [16];
    logic [1:0] range [16];
    initial
    begin
        foreach (level[i])
        begin
            level[i] = 10'h0;
            range[i] = 2'h0;
        end
    end
    // Trial above the level drops that trial bit
    assign compareHigh = analogReq.trial > level[analogReq.channel];
    assign overUpper = range[analogReq.channel][1];
    assign underLower = range[analogReq.channel][0];
endmodule
`default_nettype wire

//--- dv/acc_sva.sv
// Port checks of the converter control
`timescale 1ns/1ps
`default_nettype none
module acc_sva
    import acc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic haltMode,
    input wire acc_analog_req_type analogReq,
    input wire logic converterPowered,
    input wire logic stabilizing
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire rd = pready && !pwrite;
    wire mapped = paddr == 12'h0 || paddr == 12'h4 || paddr == 12'h8;
    a_ready_setup: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_err_unmapped: assert property (pready |-> pslverr == !mapped)
        else $error("error flag wrong");
    a_idle_data: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    a_csr_zero: assert property (rd && paddr == 12'h0 |-> prdata[31:8] == 0 && !prdata[4])
        else $error("control read bad bits");
    a_high_width: assert property (rd && paddr == 12'h4 |-> prdata[31:8] == 0)
        else $error("high byte too wide");
    a_low_zero: assert property (rd && paddr == 12'h8 |-> prdata[31:2] == 0)
        else $error("low byte upper bits set");
    a_halt_off: assert property (haltMode [*4] |-> !converterPowered && stabilizing)
        else $error("converter runs in halt");
    a_off_idle: assert property ((!converterPowered) [*2] |-> !analogReq.sample)
        else $error("sampling while off");
    c_read_high: cover property (rd && paddr == 12'h4);
    c_halt: cover property (haltMode [*4]);
    c_err: cover property (pslverr);
endmodule
`default_nettype wire

//--- dv/acc_converter_control_test.sv
// Self-checking bench of the converter control
`timescale 1ns/1ps
`default_nettype none
module acc_converter_control_test;
    import acc_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic haltMode = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic compareHigh;
    logic overUpper;
    logic underLower;
    acc_analog_req_type analogReq;
    logic converterPowered;
    logic stabilizing;
    int fails = 0;
    int total_checks = 0;
    logic [7:0] lfsr = 8'h24;
    logic [31:0] rdv;
    logic err;
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fails++; \
    $display("wrong value at %0t: got %h exp %h", $time, (g), (e)); end end
    acc_converter_control #(.STAB_CYCLES(20)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .compareHigh(compareHigh),
        .overUpper(overUpper), .underLower(underLower), .haltMode(haltMode),
        .analogReq(analogReq), .converterPowered(converterPowered),
        .stabilizing(stabilizing));
    acc_analog_model i_ana (.analogReq(analogReq), .compareHigh(compareHigh),
        .overUpper(overUpper), .underLower(underLower));
    function automatic logic [7:0] next_rand(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic wait_eoc();
        rdv = 32'h0;
        while (rdv[7] !== 1'b1) apb(1'b0, 12'h0, 32'h0);
    endtask
    task automatic convert(input logic [3:0] ch, input logic sp);
        logic [9:0] ex;
        logic [1:0] rg;
        lfsr = next_rand(lfsr);
        rg = (ch == 4'hE) ? 2'h2 : (ch == 4'hF) ? 2'h1 : 2'h0;
        i_ana.level[ch] = {lfsr, lfsr[7:6]};
        i_ana.range[ch] = rg;
        ex = rg[1] ? 10'h3FF : rg[0] ? 10'h0 : {lfsr, lfsr[7:6]};
        apb(1'b1, 12'h0, {24'h0, 1'b0, sp, 1'b1, 1'b0, ch});
        wait_eoc();
        apb(1'b0, 12'h8, 32'h0);
        `CHK(rdv, {30'h0, ex[1:0]})
        apb(1'b0, 12'h4, 32'h0);
        `CHK(rdv, {24'h0, ex[9:2]})
        apb(1'b0, 12'h0, 32'h0);
        `CHK(rdv, {24'h0, 1'b0, sp, 1'b1, 1'b0, ch})
    endtask
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    initial
    begin
        #200000;
        fails++;
        end_sim();
    end
    initial
    begin
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        apb(1'b0, 12'h0, 32'h0);
        `CHK(rdv, 32'h0)
        apb(1'b1, 12'hC, 32'hFF);
        `CHK({err, rdv}, {1'b1, 32'h0})
        // Channels 14 and 15 carry over and under range
        for (int c = 0; c < 16; c++) convert(c[3:0], c[0]);
        wait_eoc();
        apb(1'b1, 12'h0, 32'h2F);
        apb(1'b0, 12'h0, 32'h0);
        `CHK(rdv[7], 1'b0)
        haltMode <= 1'b1;
        repeat (8) @(posedge clk_sys);
        `CHK({converterPowered, stabilizing}, 2'b01)
        haltMode <= 1'b0;
        repeat (8) @(posedge clk_sys);
        `CHK(stabilizing, 1'b1)
        repeat (30) @(posedge clk_sys);
        `CHK({converterPowered, stabilizing}, 2'b10)
        apb(1'b1, 12'h0, 32'h0F);
        repeat (100) @(posedge clk_sys);
        apb(1'b0, 12'h0, 32'h0);
        `CHK(rdv, 32'h0F)
        end_sim();
    end
endmodule
bind acc_converter_control acc_sva i_sva (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .haltMode(haltMode), .analogReq(analogReq),
    .converterPowered(converterPowered), .stabilizing(stabilizing));
`default_nettype wire
